/* src/tpc_payload_ctrl.sv */
// Transmit/receive payload control of a 24-channel T1 framer:
// substitution, zero suppression, signaling trunk and snapshot,
// plus the indirect per-channel register path, over APB.
// Assumes streams arrive from logic on core_clk, one slot a cycle.
//
// Functional notes
// - Code 001: all-zero sets bit 8, sigframe bit 7
// - Code 010: bit 8 of every channel forced
// - Code 011: all-zero channel gets bit 7 set
// - Code 100: all-zero channel becomes 10011000
// - Code 000 off; other codes reserved
// - Global 000: per-channel substitution select applies
// - Global 001: channel data trunk code
// - Global 010: A-law milliwatt sequence
// - Global 011: mu-law milliwatt sequence
// - Global 100: loopback data from elastic store
// - Position bit moves AB into upper nibble pair
// - Enable bit gates all transmit functions
// - Busy high during indirect access; host waits
// - Direction bit 7: 0 write, 1 read
// - Valid indirect addresses 01-18, 21-38, 41-58
// - Read command returns byte in data register
// - Snapshot holds first frame signaling
// - Global trunk bit overrides per-channel trunk enable
// - Suppression and substitution in transmit config
`timescale 1ns/1ps
`include "tpc_consts.svh"

module tpc_payload_ctrl
    import tpc_pkg::*;
(
    input  wire logic        core_clk,    // 40 MHz clock
    input  wire logic        rst_n,       // Async reset, active low
    input  wire logic        ce,          // Clock enable, freezes all but reset release
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error on unmapped
    input  wire tpc_tx_t     tx_in,       // Transmit slot in
    input  wire logic [7:0]  lb_data,     // Elastic store loopback
    output tpc_out_t         tx_out,      // Transmit slot out
    input  wire tpc_rx_t     rx_in,       // Receive slot in
    output tpc_out_t         rx_out,      // Receive slot out
    output logic             busy         // Indirect access busy
);

    // ======================================================
    // Reset release
    logic       rst_meta;                 // First stage
    logic       rst_sync_n;               // Released reset

    // Released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ======================================================
    // APB decode
    logic [9:0] idx;                      // Register index
    logic       mapped;                   // Address hits a register
    logic       wr_en;                    // Write takes effect
    logic       setup;                    // Setup phase

    assign idx   = paddr[11:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && mapped && ce;
    assign pready = 1'b1;                 // Always one access cycle

    // Decode the six word slots
    always_comb
    begin
        mapped = (paddr[1:0] == 2'h0) &&
                 (idx >= `TPC_IDX_TX_CFG) && (idx <= `TPC_IDX_RX_CFG);
        pslverr = psel && penable && !mapped;
    end

    // ======================================================
    // Registers and indirect sequencer
    logic [7:0]  tx_cfg, next_tx_cfg;     // Transmit config
    logic [7:0]  tx_en, next_tx_en;       // Enable and position
    logic [7:0]  acc_ctrl, next_acc_ctrl; // Direction and address
    logic [7:0]  acc_data, next_acc_data; // Indirect data byte
    logic [7:0]  rx_cfg, next_rx_cfg;     // Receive config
    logic [31:0] next_prdata;             // Read data capture
    tpc_state_t  state, next_state;       // Sequencer state
    logic [7:0]  ind_mem [0:127];         // Per-channel indirect map
    logic        mem_we;                  // Indirect write strobe
    logic [6:0]  acc_addr;                // Indirect target
    logic        addr_ok;                 // Target in a bank

    assign acc_addr = acc_ctrl[6:0];
    assign busy     = (state != TPC_IDLE);

    // Banks 01-18, 21-38, 41-58
    always_comb
    begin
        addr_ok = ((acc_addr >= 7'h01) && (acc_addr <= 7'h18)) ||
                  ((acc_addr >= 7'h21) && (acc_addr <= 7'h38)) ||
                  ((acc_addr >= 7'h41) && (acc_addr <= 7'h58));
    end

    // Next values of the register group
    always_comb
    begin
        next_tx_cfg   = tx_cfg;
        next_tx_en    = tx_en;
        next_acc_ctrl = acc_ctrl;
        next_acc_data = acc_data;
        next_rx_cfg   = rx_cfg;
        next_state    = state;
        next_prdata   = prdata;
        mem_we        = 1'b0;
        // Bus writes
        if (wr_en)
        begin
            case (idx)
                `TPC_IDX_TX_CFG:   next_tx_cfg = pwdata[7:0];
                `TPC_IDX_TX_EN:    next_tx_en  = {4'h0, pwdata[3], 2'h0,
                                                  pwdata[0]};
                `TPC_IDX_ACC_CTRL:
                    // A command while busy is refused
                    if (state == TPC_IDLE)
                    begin
                        next_acc_ctrl = pwdata[7:0];
                        next_state    = TPC_XFER;
                    end
                `TPC_IDX_ACC_DATA: next_acc_data = pwdata[7:0];
                `TPC_IDX_RX_CFG:   next_rx_cfg = {pwdata[7:6], 3'h0,
                                                  pwdata[2:0]};
                default:           next_rx_cfg = rx_cfg; // Status is RO
            endcase
        end
        // Sequencer
        case (state)
            TPC_IDLE: ;
            TPC_XFER:
            begin
                if (addr_ok)
                begin
                    if (acc_ctrl[`TPC_BIT_DIR])
                        next_acc_data = ind_mem[acc_addr];
                    else
                        mem_we = 1'b1;
                end
                else if (acc_ctrl[`TPC_BIT_DIR])
                    next_acc_data = `TPC_RST_ZERO;  // Invalid reads 00
                next_state = TPC_DONE;
            end
            TPC_DONE: next_state = TPC_IDLE;    // Data stable now
            default:  next_state = TPC_IDLE;
        endcase
        // Read data loaded in setup
        if (setup)
        begin
            case (idx)
                `TPC_IDX_TX_CFG:   next_prdata = {24'h0, tx_cfg};
                `TPC_IDX_TX_EN:    next_prdata = {24'h0, tx_en};
                `TPC_IDX_ACC_STAT: next_prdata = {31'h0, busy};
                `TPC_IDX_ACC_CTRL: next_prdata = {24'h0, acc_ctrl};
                `TPC_IDX_ACC_DATA: next_prdata = {24'h0, acc_data};
                `TPC_IDX_RX_CFG:   next_prdata = {24'h0, rx_cfg};
                default:           next_prdata = 32'h0;
            endcase
        end
    end

    // Register the group
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            tx_cfg   <= `TPC_RST_CFG;
            tx_en    <= `TPC_RST_ZERO;
            acc_ctrl <= `TPC_RST_ZERO;
            acc_data <= `TPC_RST_ZERO;
            rx_cfg   <= `TPC_RST_CFG;
            state    <= TPC_IDLE;
            prdata   <= 32'h0;
        end
        else if (ce)
        begin
            tx_cfg   <= next_tx_cfg;
            tx_en    <= next_tx_en;
            acc_ctrl <= next_acc_ctrl;
            acc_data <= next_acc_data;
            rx_cfg   <= next_rx_cfg;
            state    <= next_state;
            prdata   <= next_prdata;
        end
    end

    // Indirect map, cleared at reset
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            for (int i = 0; i < 128; i++)
                ind_mem[i] <= 8'h0;
        end
        else if (ce && mem_we)
            ind_mem[acc_addr] <= acc_data;
    end

    // ======================================================
    // Milliwatt sequences, eight frames long
    function automatic logic [7:0] alaw_mw(input logic [2:0] ph);
        case (ph)
            3'h0, 3'h3: alaw_mw = 8'h34;
            3'h1, 3'h2: alaw_mw = 8'h21;
            3'h4, 3'h7: alaw_mw = 8'hB4;
            default:    alaw_mw = 8'hA1;
        endcase
    endfunction

    function automatic logic [7:0] mulaw_mw(input logic [2:0] ph);
        case (ph)
            3'h0, 3'h3: mulaw_mw = 8'h1E;
            3'h1, 3'h2: mulaw_mw = 8'h0B;
            3'h4, 3'h7: mulaw_mw = 8'h9E;
            default:    mulaw_mw = 8'h8B;
        endcase
    endfunction

    // ======================================================
    // Transmit path
    logic [2:0]  mw_ph, next_mw_ph;       // Milliwatt phase
    tpc_out_t    next_tx_out;             // Next transmit slot
    logic [2:0]  tx_sel;                  // Effective substitution
    logic [7:0]  tx_strk;                 // Trunk entry of channel
    logic [2:0]  zero_suppress_sel;                     // Suppression select

    assign zero_suppress_sel = tx_cfg[`TPC_ZCS_HI:`TPC_ZCS_LO];

    // Substitute, condition signaling, then suppress zeros
    always_comb
    begin
        next_mw_ph  = mw_ph;
        next_tx_out = '{valid: tx_in.valid, chan: tx_in.chan,
                        data: tx_in.data, sig: tx_in.sig};
        tx_strk = ind_mem[7'(tx_in.chan) + `TPC_BASE_STRK];
        tx_sel  = tx_cfg[`TPC_GSUB_HI:0];
        if (tx_sel == 3'h0)
            tx_sel = ind_mem[7'(tx_in.chan) + `TPC_BASE_CHAN_SEL_A][7:5];
        // Phase steps after the last channel
        if (tx_in.valid && (tx_in.chan == `TPC_LAST_CHAN))
            next_mw_ph = mw_ph + 3'h1;
        // Disabled block passes data untouched
        if (tx_en[`TPC_BIT_ENABLE])
        begin
            case (tx_sel)
                3'h1: next_tx_out.data =
                          ind_mem[7'(tx_in.chan) + `TPC_BASE_CHAN_DATA_TRUNK_CODE];
                3'h2: next_tx_out.data = alaw_mw(mw_ph);
                3'h3: next_tx_out.data = mulaw_mw(mw_ph);
                3'h4: next_tx_out.data = lb_data;
                default: next_tx_out.data = tx_in.data;      // Reserved
            endcase
            // Four-state signaling keeps only A and B
            if (tx_in.esf_fmt && tx_en[`TPC_BIT_SIGPOS])
                next_tx_out.sig = {tx_in.sig[3:2], 2'h0};
            if (tx_cfg[`TPC_BIT_GTRK] || tx_strk[`TPC_BIT_CHTRK])
                next_tx_out.sig = tx_strk[3:0];
            // Bit 8 is data[0], bit 7 is data[1]
            case (zero_suppress_sel)
                3'h1:
                    if (next_tx_out.data == 8'h0)
                    begin
                        if (tx_in.sig_frame)
                            next_tx_out.data[1] = 1'b1;
                        else
                            next_tx_out.data[0] = 1'b1;
                    end
                3'h2: next_tx_out.data[0] = 1'b1;
                3'h3:
                    if (next_tx_out.data == 8'h0)
                        next_tx_out.data[1] = 1'b1;
                3'h4:
                    if (next_tx_out.data == 8'h0)
                        next_tx_out.data = `TPC_DDS_CODE;
                default: ;
            endcase
        end
    end

    // Register transmit group
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mw_ph  <= 3'h0;
            tx_out <= '0;
        end
        else if (ce)
        begin
            mw_ph  <= next_mw_ph;
            tx_out <= next_tx_out;
        end
    end

    // ======================================================
    // Receive path
    logic [3:0]  snap [0:23];             // Held signaling per channel
    logic [3:0]  next_snap [0:23];        // Next held signaling
    tpc_out_t    next_rx_out;             // Next receive slot
    logic [7:0]  rx_strk;                 // Trunk entry of channel
    logic        snap_on;                 // Snapshot active

    assign snap_on = rx_cfg[`TPC_BIT_SNAP] && rx_in.in_sync;

    // One latch per channel, loaded in frame one
    for (genvar c = 0; c < 24; c++)
    begin : g_snap
        always_comb
        begin
            next_snap[c] = snap[c];
            if (rx_in.valid && rx_in.mf_first && (rx_in.chan == 5'(c)))
                next_snap[c] = rx_in.sig;
        end
        always_ff @(posedge core_clk or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
                snap[c] <= 4'h0;
            else if (ce)
                snap[c] <= next_snap[c];
        end
    end

    // Substitution and signaling for the receive side
    always_comb
    begin
        next_rx_out = '{valid: rx_in.valid, chan: rx_in.chan,
                        data: rx_in.data, sig: rx_in.sig};
        rx_strk = ind_mem[7'(rx_in.chan) + `TPC_BASE_STRK];
        // Hold the first frame's bits for the whole multiframe
        if (snap_on && !rx_in.mf_first && (rx_in.chan <= `TPC_LAST_CHAN))
            next_rx_out.sig = snap[rx_in.chan];
        case (rx_cfg[`TPC_GSUB_HI:0])
            3'h1: next_rx_out.data =
                      ind_mem[7'(rx_in.chan) + `TPC_BASE_CHAN_DATA_TRUNK_CODE];
            3'h2: next_rx_out.data = alaw_mw(mw_ph);
            3'h3: next_rx_out.data = mulaw_mw(mw_ph);
            default: next_rx_out.data = rx_in.data;
        endcase
        if (rx_cfg[`TPC_BIT_GTRK] || rx_strk[`TPC_BIT_CHTRK])
            next_rx_out.sig = rx_strk[3:0];
    end

    // Register receive slot
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rx_out <= '0;
        else if (ce)
            rx_out <= next_rx_out;
    end

endmodule // tpc_payload_ctrl

/* src/tpc_consts.svh */
// Register indexes, field positions, reset values, map bounds.
// Included by the design; definitions only.
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define TPC_IDX_TX_CFG      10'h0CB
`define TPC_IDX_TX_EN       10'h0CC
`define TPC_IDX_ACC_STAT    10'h0CD
`define TPC_IDX_ACC_CTRL    10'h0CE
`define TPC_IDX_ACC_DATA    10'h0CF
`define TPC_IDX_RX_CFG      10'h0D0

// ==========================================================
// Reset values
`define TPC_RST_CFG         8'h80
`define TPC_RST_ZERO        8'h00

// ==========================================================
// Field positions
`define TPC_BIT_SNAP        7
`define TPC_BIT_GTRK        6
`define TPC_ZCS_HI          5
`define TPC_ZCS_LO          3
`define TPC_GSUB_HI         2
`define TPC_BIT_SIGPOS      3
`define TPC_BIT_ENABLE      0
`define TPC_BIT_DIR         7
`define TPC_BIT_CHTRK       4

// ==========================================================
// Indirect map: bank bases and last channel
`define TPC_BASE_CHAN_SEL_A      7'h01
`define TPC_BASE_CHAN_DATA_TRUNK_CODE       7'h21
`define TPC_BASE_STRK       7'h41
`define TPC_LAST_CHAN       5'h17
`define TPC_DDS_CODE        8'h98

`endif

/* src/tpc_pkg.sv */
// Types shared by the payload control block and its bench.
// Assumes tpc_consts.svh sits beside it on the include path.
package tpc_pkg;

    // Indirect access sequencer, gray along idle-xfer-done
    typedef enum logic [1:0]
    {
        TPC_IDLE = 2'h0,
        TPC_XFER = 2'h1,
        TPC_DONE = 2'h3
    } tpc_state_t;

    // One transmit channel slot
    typedef struct packed
    {
        logic       valid;     // Slot present
        logic [4:0] chan;      // Channel 0..23
        logic       sig_frame; // Signaling frame
        logic       esf_fmt;   // ESF or SLC-96 format
        logic [7:0] data;      // Octet, bit 1 is data[7]
        logic [3:0] sig;       // ABCD in [3:0]
    } tpc_tx_t;

    // One receive channel slot
    typedef struct packed
    {
        logic       valid;     // Slot present
        logic [4:0] chan;      // Channel 0..23
        logic       mf_first;  // First frame of multiframe
        logic       in_sync;   // SF/ESF/SLC-96 framing in sync
        logic [7:0] data;      // Octet
        logic [3:0] sig;       // ABCD
    } tpc_rx_t;

    // Processed output slot
    typedef struct packed
    {
        logic       valid;     // Slot present
        logic [4:0] chan;      // Channel
        logic [7:0] data;      // Octet
        logic [3:0] sig;       // ABCD
    } tpc_out_t;

endpackage

/* testbench/tpc_payload_ctrl_sva.sv */
// Checker for the payload control block, bound from the bench.
// Assumes APB byte addresses of the register map and pready high.
`timescale 1ns/1ps
module tpc_payload_ctrl_sva
    import tpc_pkg::*;
(
    input  wire logic        core_clk, // Clock
    input  wire logic        rst_n,    // Reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB direction
    input  wire logic [11:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    input  wire logic        pslverr,  // APB error
    input  wire tpc_tx_t     tx_in,    // Transmit slot in
    input  wire tpc_out_t    tx_out,   // Transmit slot out
    input  wire tpc_rx_t     rx_in,    // Receive slot in
    input  wire tpc_out_t    rx_out,   // Receive slot out
    input  wire logic        busy      // Indirect busy
);
    // ========================================================
    // Shadow copies of the mode registers
    logic [7:0] cfg_m; // Transmit config copy
    logic [7:0] en_m;  // Transmit enable copy
    logic       wr_ok; // Write committed at this edge

    assign wr_ok = psel && penable && pwrite;

    // Shadows bus writes
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_m <= 8'h80;
            en_m  <= 8'h00;
        end
        else if (wr_ok && paddr == 12'h32C)
            cfg_m <= pwdata[7:0];
        else if (wr_ok && paddr == 12'h330)
            en_m <= pwdata[7:0];
    end

    // ========================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("stray bus error");
    unmapped_err_a: assert property (
        psel && penable && paddr == 12'h3F0 |-> pslverr)
        else $error("no bus error");
    tx_latency_a: assert property ($past(rst_n, 3) |->
        tx_out.valid == $past(tx_in.valid))
        else $error("tx slot late");
    rx_latency_a: assert property ($past(rst_n, 3) |->
        rx_out.valid == $past(rx_in.valid))
        else $error("rx slot late");
    busy_len_a: assert property (
        $rose(busy) |-> busy[*2] ##1 !busy)
        else $error("busy length wrong");
    busy_cause_a: assert property (
        wr_ok && paddr == 12'h338 && !busy |=> busy)
        else $error("busy not raised");
    busy_source_a: assert property (
        $rose(busy) |-> $past(wr_ok && paddr == 12'h338))
        else $error("stray busy");
    pass_off_a: assert property (
        tx_out.valid && !en_m[0] |-> tx_out.data == $past(tx_in.data))
        else $error("data altered");
    jam_bit8_a: assert property (
        tx_out.valid && en_m[0] && cfg_m[5:3] == 3'h2 |-> tx_out.data[0])
        else $error("bit 8 not forced");
    dds_nonzero_a: assert property (
        tx_out.valid && en_m[0] && cfg_m[5:3] == 3'h4
        |-> tx_out.data != 8'h00)
        else $error("zero octet kept");
endmodule // tpc_payload_ctrl_sva

/* testbench/tpc_host_model.sv */
// Host processor model: APB master and indirect access sequences.
// Assumes the slave answers within the bench timeout.
`timescale 1ns/1ps
module tpc_host_model
(
    input  wire logic        core_clk, // Bus clock
    output logic             psel,     // Select
    output logic             penable,  // Access phase
    output logic             pwrite,   // Direction
    output logic [11:0]      paddr,    // Byte address
    output logic [31:0]      pwdata,   // Write data
    input  wire logic [31:0] prdata,   // Read data
    input  wire logic        pready,   // Ready
    input  wire logic        pslverr   // Error
);
    logic [7:0] rd_q;  // Last byte read
    logic       err_q; // Last error flag

    initial {psel, penable, pwrite, paddr, pwdata} = '0; // Idle bus

    // One transfer; request held until pready seen at an edge
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [7:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd_q    = prdata[7:0];
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= {24'hFFFFFF, ~d}; // No stale data
    endtask

    // Poll status; no new command while busy
    task automatic idle_wait();
        xfer(12'h334, 1'b0, 8'h00);
        for (int n = 0; n < 16 && rd_q[0] !== 1'b0; n++)
            xfer(12'h334, 1'b0, 8'h00);
    endtask

    // Data first, then command with direction clear
    task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
        xfer(12'h33C, 1'b1, d);
        xfer(12'h338, 1'b1, {1'b0, a});
        idle_wait();
    endtask

    // Command with direction set, then fetch the data byte
    task automatic ind_rd(input logic [6:0] a);
        xfer(12'h338, 1'b1, {1'b1, a});
        idle_wait();
        xfer(12'h33C, 1'b0, 8'h00);
    endtask
endmodule // tpc_host_model

/* testbench/t1_payload_control_bench.sv */
// Self-checking bench: registers, indirect path, both streams.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`define CHECK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("unexpected %s expected %h seen %h", nm, e, g); \
        end \
    end

module t1_payload_control_bench
    import tpc_pkg::*;
;
    logic        core_clk = 1'b0; // 40 MHz clock
    logic        rst_n;           // Reset, active low
    logic        ce;              // Clock enable, held on
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;           // Bus address
    logic [31:0] pwdata, prdata;  // Bus data
    tpc_tx_t     tx_in;           // Transmit slot in
    tpc_rx_t     rx_in;           // Receive slot in
    tpc_out_t    tx_out, rx_out;  // Slots out
    logic [7:0]  lb_data;         // Loopback byte
    logic        busy;            // Indirect busy
    int          num_errors = 0;  // Mismatches
    int          n_compared = 0;  // Comparisons

    always #12.5 core_clk = ~core_clk;

    tpc_payload_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_in(tx_in), .lb_data(lb_data),
        .tx_out(tx_out), .rx_in(rx_in), .rx_out(rx_out), .busy(busy));

    tpc_host_model HOST (.core_clk(core_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ========================================================
    // Helpers
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Channel 5 slot on both streams; outputs settled on return
    task automatic slot(input logic f, input logic [7:0] d,
                        input logic [3:0] s);
        @(posedge core_clk);
        tx_in <= '{1'b1, 5'h05, f, 1'b1, d, s};
        rx_in <= '{1'b1, 5'h05, f, 1'b1, 8'h55, s};
        @(posedge core_clk);
        tx_in.valid <= 1'b0;
        rx_in.valid <= 1'b0;
        #1;
    endtask

    function automatic logic [7:0] zcs_exp(int c, logic [7:0] d,
                                           logic sf);
        case (c)
            1: return (d == 8'h00) ? (sf ? 8'h02 : 8'h01) : d;
            2: return d | 8'h01;
            3: return (d == 8'h00) ? 8'h02 : d;
            4: return (d == 8'h00) ? 8'h98 : d;
            default: return d;
        endcase
    endfunction

    // ========================================================
    // Scenarios
    task automatic t_regs();
        for (int i = 0; i < 6; i++)
        begin
            HOST.xfer(12'h32C + 12'(4 * i), 1'b0, 8'h00);
            `CHECK("reset value", (i % 5) ? 8'h00 : 8'h80, HOST.rd_q)
        end
        HOST.xfer(12'h3F0, 1'b0, 8'h00);
        `CHECK("unmapped error", 1'b1, HOST.err_q)
        HOST.xfer(12'h334, 1'b1, 8'h01);
        HOST.xfer(12'h334, 1'b0, 8'h00);
        `CHECK("status read only", 8'h00, HOST.rd_q)
        $display("test regs done");
    endtask

    task automatic t_indirect();
        HOST.ind_wr(7'h26, 8'hA5);
        HOST.ind_wr(7'h06, 8'h00);
        HOST.ind_rd(7'h26);
        `CHECK("indirect read", 8'hA5, HOST.rd_q)
        HOST.ind_rd(7'h19);
        `CHECK("invalid target", 8'h00, HOST.rd_q)
        $display("test indirect done");
    endtask

    task automatic t_zcs();
        logic [7:0] d;
        HOST.xfer(12'h330, 1'b1, 8'h01);
        for (int c = 0; c < 5; c++)
        begin
            HOST.xfer(12'h32C, 1'b1, {2'b00, c[2:0], 3'b000});
            for (int k = 0; k < 4; k++)
            begin
                d = k[0] ? 8'h40 : 8'h00;
                slot(k[1], d, 4'h0);
                `CHECK("suppress", zcs_exp(c, d, k[1]), tx_out.data)
            end
        end
        $display("test suppression done");
    endtask

    task automatic t_chan_sel_a();
        logic [2:0] g [4] = '{3'h1, 3'h4, 3'h2, 3'h3};
        logic [7:0] e [4] = '{8'hA5, 8'h3C, 8'h34, 8'h1E};
        for (int i = 0; i < 4; i++)
        begin
            HOST.xfer(12'h32C, 1'b1, {5'h00, g[i]});
            slot(1'b0, 8'h11, 4'h0);
            `CHECK("global chan_sel_a", e[i], tx_out.data)
        end
        HOST.ind_wr(7'h06, 8'h20);
        HOST.xfer(12'h32C, 1'b1, 8'h00);
        slot(1'b0, 8'h11, 4'h0);
        `CHECK("channel chan_sel_a", 8'hA5, tx_out.data)
        HOST.xfer(12'h330, 1'b1, 8'h00);
        slot(1'b0, 8'h11, 4'h0);
        `CHECK("disabled path", 8'h11, tx_out.data)
        $display("test substitution done");
    endtask

    task automatic t_sig();
        HOST.xfer(12'h330, 1'b1, 8'h09);
        slot(1'b0, 8'h11, 4'hF);
        `CHECK("sig position", 4'hC, tx_out.sig)
        HOST.ind_wr(7'h46, 8'h05);
        HOST.xfer(12'h32C, 1'b1, 8'h40);
        slot(1'b0, 8'h11, 4'hF);
        `CHECK("global trunk", 4'h5, tx_out.sig)
        HOST.ind_wr(7'h46, 8'h17);
        HOST.xfer(12'h32C, 1'b1, 8'h00);
        slot(1'b0, 8'h11, 4'hF);
        `CHECK("channel trunk", 4'h7, tx_out.sig)
        $display("test signaling done");
    endtask

    task automatic t_rx();
        HOST.ind_wr(7'h46, 8'h07);
        slot(1'b1, 8'h11, 4'hA);
        `CHECK("first frame sig", 4'hA, rx_out.sig)
        slot(1'b0, 8'h11, 4'h3);
        `CHECK("snapshot held", 4'hA, rx_out.sig)
        HOST.xfer(12'h340, 1'b1, 8'h00);
        slot(1'b0, 8'h11, 4'h3);
        `CHECK("snapshot off", 4'h3, rx_out.sig)
        $display("test snapshot done");
    endtask

    // ========================================================
    // Main sequence
    initial
    begin
        rst_n   = 1'b0;
        ce      = 1'b1;
        tx_in   = '0;
        rx_in   = '0;
        lb_data = 8'h3C;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_indirect();
        t_zcs();
        t_chan_sel_a();
        t_sig();
        t_rx();
        results();
    end

    // Watchdog at 20000 cycles
    initial
    begin
        #500000;
        num_errors++;
        results();
    end
endmodule // t1_payload_control_bench

bind tpc_payload_ctrl tpc_payload_ctrl_sva u_chk (.core_clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .tx_in,
    .tx_out, .rx_in, .rx_out, .busy);
